// ==== pkg/ptg_pkg.sv ====
// Package for the four-channel pulse train generator bank.
// Assumes a byte-wide data memory bus with one-cycle reads and writes.
package ptg_pkg;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 5;
   // Register indices: four bytes per channel, then two control bytes
   localparam logic [4:0] PRESCALER_LOW_BYTE_OFS = 5'h00;
   localparam logic [4:0] PRESCALER_HIGH_BYTE_OFS = 5'h01;
   localparam logic [4:0] PULSE_COUNT_LOW_BYTE_OFS = 5'h02;
   localparam logic [4:0] PULSE_COUNT_HIGH_BYTE_OFS = 5'h03;
   localparam logic [4:0] CHAN_STRIDE = 5'h04;
   localparam logic [4:0] CHANNELS_ONE_TWO_CONTROL_OFS = 5'h10;
   localparam logic [4:0] CHANNELS_THREE_FOUR_CONTROL_OFS = 5'h11;
   // Control nibble field positions
   localparam int unsigned GO_BIT = 0;
   localparam int unsigned IRQ_ALLOW_BIT = 1;
   localparam int unsigned IRQ_FLAG_BIT = 2;
   localparam int unsigned TEST_PATH_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } bus_req_type;

   // Packed order puts run in bit 0 so a nibble reads back as written
   typedef struct packed {
      logic test_path;
      logic irq_flag;
      logic irq_allow;
      logic go;
   } chan_ctrl_type;
endpackage

// ==== verilog/pulse_channel.sv ====
// One pulse train channel: prescaler, divide-by-two and pulse count decrement and zero detect.
// Assumes start is a one-cycle pulse when software sets the run bit.
`timescale 1ns/1ps
module pulse_channel
   import ptg_pkg::*;
#(
   parameter int unsigned WIDTH = CNT_W
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_enable,
   // Control
   input wire logic i_start,
   input wire logic i_go,
   input wire logic [WIDTH-1:0] i_prescaler,
   input wire logic [WIDTH-1:0] i_count,
   // Status
   output logic o_count_dec,
   output logic o_count_wrap,
   output logic o_out
);
   logic [WIDTH-1:0] presc_ff;
   logic half_ff;
   logic out_ff;
   logic prescaler_wrap_pulse;
   logic half_rate_wrap_pulse;

   assign prescaler_wrap_pulse = i_go && !i_start && (presc_ff == '0);
   assign half_rate_wrap_pulse = prescaler_wrap_pulse && half_ff;
   assign o_count_dec = half_rate_wrap_pulse;
   // [R16] Last pulse ends on zero count
   assign o_count_wrap = half_rate_wrap_pulse && (i_count == '0);
   assign o_out = out_ff;

   // [R13] Reload prescaler
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         presc_ff <= '0;
      end else if (i_enable) begin
         if (i_start || prescaler_wrap_pulse) begin
            presc_ff <= i_prescaler;
         end else if (i_go) begin
            presc_ff <= presc_ff - 1'b1;
         end
      end
   end

   // [R14] Divide by two, cleared on start
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         half_ff <= 1'b0;
      end else if (i_enable) begin
         if (i_start) begin
            half_ff <= 1'b0;
         end else if (prescaler_wrap_pulse) begin
            half_ff <= !half_ff;
         end
      end
   end

   // [R02] [R13] Toggle output; frozen while stopped
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         out_ff <= 1'b0;
      end else if (i_enable && prescaler_wrap_pulse) begin
         out_ff <= !out_ff;
      end
   end

   // [R02] Every half period restarts from the full prescaler value
   equal_halves_a: assert property ( // [R02]
      @(posedge i_clock) disable iff (!i_rstn)
      prescaler_wrap_pulse && i_enable |=> presc_ff == $past(i_prescaler))
      else $error("half period not reloaded");
endmodule // pulse_channel

// ==== verilog/pulse_train_bank.sv ====
// Bank of four pulse train generators behind a byte data memory bus.
// Assumes bus accesses are synchronous to i_clock; outputs feed port pins.
// How it works
// [R01] Four independent channels, each with 16-bit prescaler and count.
// [R02] Each channel emits counted pulses with equal high and low time.
// [R03] Writing run bit one starts, zero stops, per channel only.
// [R04] Count underflow may request an interrupt when enable bit is set.
// [R05] Prescaler and count are byte registers readable and writable.
// [R06] Low and high bytes form each 16-bit prescaler and count.
// [R07] First control byte holds channels one and two nibbles.
// [R08] Second control byte holds channels three and four nibbles.
// [R09] Enable gates the request; pending flag itself stays intact.
// [R10] Count underflow sets the pending bit.
// [R11] Only software clears pending; hardware never clears it.
// [R12] Software keeps test bits at zero.
// [R13] Prescaler underflow toggles output and reloads prescaler.
// [R14] Count decrements on every second prescaler underflow.
// [R15] Count underflow clears run bit and sets pending.
// [R16] Pulses equal high count byte times 256 plus low plus one.
// [R17] One shared interrupt from any pending and enabled channel.
// [R18] Reset clears control bits and divider, keeps byte registers.
`timescale 1ns/1ps
module pulse_train_bank
   import ptg_pkg::*;
#(
   parameter int unsigned CHANNELS = NUM_CHAN
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_enable,
   // Data memory bus
   input wire bus_req_type i_bus,
   output logic [7:0] o_rdata,
   // Pins and interrupt
   output logic [CHANNELS-1:0] o_pulse,
   output logic o_irq
);
   logic [CNT_W-1:0] presc_ff [CHANNELS];
   logic [CNT_W-1:0] count_ff [CHANNELS];
   chan_ctrl_type ctrl_ff [CHANNELS];
   logic [CHANNELS-1:0] start;
   logic [CHANNELS-1:0] dec;
   logic [CHANNELS-1:0] pulse_count_wrap_pulse;
   logic [CHANNELS-1:0] irq_terms;
   logic [7:0] rdata_ff;

   genvar g;
   // [R01] One independent channel per pass
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         localparam logic [4:0] BASE = 5'(g * CHAN_STRIDE);
         localparam logic [4:0] CTRL_ADDR = (g < 2) ?
            CHANNELS_ONE_TWO_CONTROL_OFS : CHANNELS_THREE_FOUR_CONTROL_OFS;
         localparam int unsigned NIB = (g % 2) * 4;
         logic ctrl_wr;
         logic [3:0] wnib;
         assign ctrl_wr = i_bus.wr && (i_bus.addr == CTRL_ADDR);
         assign wnib = i_bus.wdata[NIB +: 4];
         // [R03] Start pulse on run rising from software
         assign start[g] = ctrl_wr && wnib[GO_BIT] && !ctrl_ff[g].go;

         // [R05] Byte registers, untouched by reset
         always_ff @(posedge i_clock) begin
            if (i_enable && i_bus.wr) begin
               if (i_bus.addr == BASE + PRESCALER_LOW_BYTE_OFS)
                  presc_ff[g][7:0] <= i_bus.wdata;
               if (i_bus.addr == BASE + PRESCALER_HIGH_BYTE_OFS)
                  presc_ff[g][15:8] <= i_bus.wdata;
            end
         end

         // [R14] Count register, decremented once per pulse
         always_ff @(posedge i_clock) begin
            if (i_enable) begin
               if (i_bus.wr && i_bus.addr == BASE + PULSE_COUNT_LOW_BYTE_OFS)
                  count_ff[g][7:0] <= i_bus.wdata;
               else if (i_bus.wr &&
                        i_bus.addr == BASE + PULSE_COUNT_HIGH_BYTE_OFS)
                  count_ff[g][15:8] <= i_bus.wdata;
               else if (dec[g])
                  count_ff[g] <= count_ff[g] - 1'b1;
            end
         end

         // [R07] [R08] Control nibble with run clear and pending set
         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               // [R18] Control bits cleared
               ctrl_ff[g] <= chan_ctrl_type'(CTRL_RESET);
            end else if (i_enable) begin
               if (ctrl_wr) begin
                  ctrl_ff[g].go <= wnib[GO_BIT];
                  ctrl_ff[g].irq_allow <= wnib[IRQ_ALLOW_BIT];
                  ctrl_ff[g].irq_flag <= wnib[IRQ_FLAG_BIT];
                  ctrl_ff[g].test_path <= wnib[TEST_PATH_BIT];
               end
               // [R15] Underflow stops channel; set wins over write
               if (pulse_count_wrap_pulse[g]) begin
                  ctrl_ff[g].go <= 1'b0;
                  // [R10] [R11] Pending set by hardware, never cleared by it
                  ctrl_ff[g].irq_flag <= 1'b1;
               end
            end
         end

         pulse_channel #(
            .WIDTH(CNT_W)
         ) u_chan (
            .i_clock(i_clock),
            .i_rstn(i_rstn),
            .i_enable(i_enable),
            .i_start(start[g]),
            .i_go(ctrl_ff[g].go),
            .i_prescaler(presc_ff[g]),
            .i_count(count_ff[g]),
            .o_count_dec(dec[g]),
            .o_count_wrap(pulse_count_wrap_pulse[g]),
            .o_out(o_pulse[g])
         );

         // [R09] Enable gates request only
         assign irq_terms[g] = ctrl_ff[g].irq_flag && ctrl_ff[g].irq_allow;

         // [R10] Underflow sets pending
         flag_set_a: assert property ( // [R10]
            @(posedge i_clock) disable iff (!i_rstn)
            pulse_count_wrap_pulse[g] && i_enable |=> ctrl_ff[g].irq_flag)
            else $error("pending not set on underflow");

         // [R15] Underflow stops channel
         wrap_stop_a: assert property ( // [R15]
            @(posedge i_clock) disable iff (!i_rstn)
            pulse_count_wrap_pulse[g] && i_enable |=> !ctrl_ff[g].go)
            else $error("run not cleared on underflow");

         // [R11] Hardware never clears pending
         flag_hold_a: assert property ( // [R11]
            @(posedge i_clock) disable iff (!i_rstn)
            ctrl_ff[g].irq_flag && !ctrl_wr |=> ctrl_ff[g].irq_flag)
            else $error("pending cleared by hardware");

         // [R03] Stopped channel freezes pin
         stop_freeze_a: assert property ( // [R03]
            @(posedge i_clock) disable iff (!i_rstn)
            !ctrl_ff[g].go |=> $stable(o_pulse[g]))
            else $error("pin moved while stopped");

         // [R04] Enabled underflow raises the shared request next cycle
         irq_any_a: assert property ( // [R04] [R17]
            @(posedge i_clock) disable iff (!i_rstn)
            pulse_count_wrap_pulse[g] && i_enable && ctrl_ff[g].irq_allow &&
            !ctrl_wr |=> o_irq)
            else $error("interrupt not raised on underflow");

         // [R14] One decrement per completed pulse
         count_dec_a: assert property ( // [R14]
            @(posedge i_clock) disable iff (!i_rstn)
            dec[g] && i_enable && !i_bus.wr |=>
            count_ff[g] == $past(count_ff[g]) - 1'b1)
            else $error("count not decremented once");
      end
   endgenerate

   // [R04] [R17] Shared interrupt request
   assign o_irq = |irq_terms;

   // [R06] Read mux; unmapped reads return zero
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_ff <= READ_UNMAPPED;
      end else if (i_enable && i_bus.rd) begin
         rdata_ff <= READ_UNMAPPED;
         for (int c = 0; c < CHANNELS; c++) begin
            if (i_bus.addr == 5'(c * CHAN_STRIDE) + PRESCALER_LOW_BYTE_OFS)
               rdata_ff <= presc_ff[c][7:0];
            if (i_bus.addr == 5'(c * CHAN_STRIDE) + PRESCALER_HIGH_BYTE_OFS)
               rdata_ff <= presc_ff[c][15:8];
            if (i_bus.addr == 5'(c * CHAN_STRIDE) + PULSE_COUNT_LOW_BYTE_OFS)
               rdata_ff <= count_ff[c][7:0];
            if (i_bus.addr == 5'(c * CHAN_STRIDE) + PULSE_COUNT_HIGH_BYTE_OFS)
               rdata_ff <= count_ff[c][15:8];
         end
         if (i_bus.addr == CHANNELS_ONE_TWO_CONTROL_OFS)
            rdata_ff <= {ctrl_ff[1], ctrl_ff[0]};
         if (i_bus.addr == CHANNELS_THREE_FOUR_CONTROL_OFS)
            rdata_ff <= {ctrl_ff[3], ctrl_ff[2]};
      end
   end
   assign o_rdata = rdata_ff;
endmodule // pulse_train_bank

// ==== tb/pin_monitor.sv ====
// Far-side model: circuitry watching the four pulse pins.
// Assumes pins are registered levels sampled on the rising clock edge.
`timescale 1ns/1ps
module pin_monitor (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // Pins from the bank
   input wire logic [3:0] i_pulse,
   // Observations
   output logic [3:0][15:0] o_toggles,
   output logic [3:0][15:0] o_width
);
   logic [3:0] prev_ff;
   logic [3:0][15:0] run_ff;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         prev_ff <= '0;
         run_ff <= '0;
         o_toggles <= '0;
         o_width <= '0;
      end else begin
         prev_ff <= i_pulse;
         for (int c = 0; c < 4; c++) begin
            if (i_pulse[c] !== prev_ff[c]) begin
               o_toggles[c] <= o_toggles[c] + 16'h0001;
               o_width[c] <= run_ff[c];
               run_ff[c] <= 16'h0001;
            end else begin
               run_ff[c] <= run_ff[c] + 16'h0001;
            end
         end
      end
   end
endmodule // pin_monitor

// ==== tb/testbench.sv ====
// Self-checking bench for the pulse train bank.
// Assumes one-cycle bus strobes and read data valid after the taking edge.
`timescale 1ns/1ps
module testbench
   import ptg_pkg::*;
();
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic i_enable = 1'b1;
   bus_req_type i_bus = '0;
   logic [7:0] o_rdata;
   logic [3:0] o_pulse;
   logic o_irq;
   logic [3:0][15:0] tog;
   logic [3:0][15:0] wid;
   logic [15:0] held;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   localparam logic [4:0] C12 = CHANNELS_ONE_TWO_CONTROL_OFS;
   localparam logic [4:0] C34 = CHANNELS_THREE_FOUR_CONTROL_OFS;

   pulse_train_bank uut (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_enable(i_enable), .i_bus(i_bus), .o_rdata(o_rdata),
      .o_pulse(o_pulse), .o_irq(o_irq));
   pin_monitor mon (.i_clock(i_clock), .i_rstn(i_rstn), .i_pulse(o_pulse),
      .o_toggles(tog), .o_width(wid));

   always #12.5 i_clock = ~i_clock;

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 320 cycles the sequence needs
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         $display("mismatch at %0t: run did not finish", $time);
         end_sim;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [4:0] a,
      input logic [7:0] d);
      @(posedge i_clock);
      i_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_clock);
      i_bus <= '0;
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk({8'h00, o_rdata}, {8'h00, e});
   endtask

   task automatic prog(input int c, input logic [15:0] p,
      input logic [15:0] n);
      wr(5'(c * 4) + PRESCALER_LOW_BYTE_OFS, p[7:0]);
      wr(5'(c * 4) + PRESCALER_HIGH_BYTE_OFS, p[15:8]);
      wr(5'(c * 4) + PULSE_COUNT_LOW_BYTE_OFS, n[7:0]);
      wr(5'(c * 4) + PULSE_COUNT_HIGH_BYTE_OFS, n[15:8]);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   initial begin
      repeat (6) @(posedge i_clock);
      i_rstn <= 1'b1;
      rd(C12, 8'h00);
      rd(C34, 8'h00);
      rd(5'h15, READ_UNMAPPED);
      for (int k = 0; k < 16; k++) begin
         wr(5'(k), 8'(8'ha0 + k));
         rd(5'(k), 8'(8'ha0 + k));
      end
      // Test bits stay zero in every control write below
      prog(0, 16'h0002, 16'h0002);
      prog(1, 16'h0000, 16'h0000);
      wr(C12, 8'h03);
      wait_cyc(40);
      chk(tog[0], 16'h0006);
      chk(wid[0], 16'h0003);
      chk(tog[1], 16'h0000);
      rd(C12, 8'h06);
      chk({15'h0, o_irq}, 16'h0001);
      wr(C12, 8'h04);
      chk({15'h0, o_irq}, 16'h0000);
      wait_cyc(20);
      rd(C12, 8'h04);
      wr(C12, 8'h00);
      rd(C12, 8'h00);
      wr(C12, 8'h10);
      wait_cyc(10);
      chk(tog[1], 16'h0002);
      chk(wid[1], 16'h0001);
      rd(C12, 8'h40);
      wr(C12, 8'h00);
      prog(3, 16'h0001, 16'h0001);
      wr(C34, 8'h30);
      wait_cyc(30);
      chk(tog[3], 16'h0004);
      chk(wid[3], 16'h0002);
      chk(tog[2], 16'h0000);
      rd(C34, 8'h60);
      chk({15'h0, o_irq}, 16'h0001);
      wr(C34, 8'h00);
      prog(2, 16'h0001, 16'h00ff);
      wr(C34, 8'h01);
      wait_cyc(20);
      wr(C34, 8'h00);
      // A toggle launched on the stopping edge is seen one cycle later
      wait_cyc(2);
      held = tog[2];
      wait_cyc(20);
      chk(tog[2], held);
      rd(C34, 8'h00);
      // Reset in mid-run: control clears, byte registers survive
      wr(C34, 8'h03);
      wait_cyc(5);
      // Clock enable low freezes a running channel
      @(posedge i_clock);
      i_enable <= 1'b0;
      wait_cyc(2);
      held = tog[2];
      wait_cyc(8);
      chk(tog[2], held);
      @(posedge i_clock);
      i_enable <= 1'b1;
      @(posedge i_clock);
      i_rstn <= 1'b0;
      wait_cyc(2);
      chk({12'h0, o_pulse}, 16'h0000);
      chk({15'h0, o_irq}, 16'h0000);
      @(posedge i_clock);
      i_rstn <= 1'b1;
      rd(C34, 8'h00);
      rd(5'h08, 8'h01);
      rd(5'h0b, 8'h00);
      wait_cyc(10);
      chk(tog[2], 16'h0000);
      end_sim;
   end
endmodule // testbench
